/* hdl/sertx_top.sv */
// Dual-channel transmit front end with AXI4-Lite registers and interrupt
`default_nettype none
// What this block does
// - Capture ten-bit character on selected clock edge
// - Per-channel latch picks capture clock source
// - Align buffer underflow or overflow raises error
// - Buffer error holds until buffer recentred
// - Each channel flags only its own errors
// - Self-test select 0 shows progress instead
// - Self-test pass pulses one character per 511
// - Both serial outputs off forces error high
// - Missing reference clock forces error high
// - Select 0 captures on channel input clock
// - Recentre 0 re-aligns buffer, clears error
// - Half-rate reference samples on both edges
module sertx_top #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned LOSS_CYCLES = sertx_pkg::REF_LOSS_CYCLES
) (
  input wire logic clock, // 40 MHz system clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic [ADDR_W-1:0] awaddr, // Write address
  input wire logic [2:0] awprot, // Write protection, unused
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [ADDR_W-1:0] araddr, // Read address
  input wire logic [2:0] arprot, // Read protection, unused
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic [9:0] chan_a_char_in, // Channel A character
  input wire logic [9:0] chan_b_char_in, // Channel B character
  input wire logic chan_a_input_clock, // Channel A input clock
  input wire logic chan_b_input_clock, // Channel B input clock
  input wire logic chan_a_reference_clock, // Channel A reference clock
  input wire logic chan_b_reference_clock, // Channel B reference clock
  output logic [9:0] chan_a_char_out, // Channel A captured character
  output logic [9:0] chan_b_char_out, // Channel B captured character
  output logic chan_a_error_flag, // Channel A error flag
  output logic chan_b_error_flag, // Channel B error flag
  output logic irq // Level interrupt
);
  localparam int unsigned CB = sertx_pkg::CFG_B_BASE;
  localparam int unsigned CW = sertx_pkg::CFG_W;

  logic [CW-1:0] cfg_a, cfg_b;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write, wr_hit;
  logic [3:0] irq_status, irq_enable, events, clr_mask;

  sertx_chan_if chan_a_link();
  sertx_chan_if chan_b_link();

  // Register word index compare
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    hit = (8'(addr) & 8'hFC) == ofs;
  endfunction

  // Known addresses, for the error response
  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    logic ok;
    ok = 1'b0;
    if (hit(addr, sertx_pkg::OFS_CONFIG)) begin
      ok = 1'b1;
    end else if (hit(addr, sertx_pkg::OFS_STATUS)) begin
      ok = 1'b1;
    end else if (hit(addr, sertx_pkg::OFS_CHAR_A)) begin
      ok = 1'b1;
    end else if (hit(addr, sertx_pkg::OFS_CHAR_B)) begin
      ok = 1'b1;
    end else if (hit(addr, sertx_pkg::OFS_IRQ_STATUS)) begin
      ok = 1'b1;
    end else if (hit(addr, sertx_pkg::OFS_IRQ_CLEAR)) begin
      ok = 1'b1;
    end else if (hit(addr, sertx_pkg::OFS_IRQ_ENABLE)) begin
      ok = 1'b1;
    end
    mapped = ok;
  endfunction

  // Read data mux; the clear register reads as zero
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] addr);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (hit(addr, sertx_pkg::OFS_CONFIG)) begin
      d[CW-1:0] = cfg_a;
      d[CB+CW-1:CB] = cfg_b;
    end else if (hit(addr, sertx_pkg::OFS_STATUS)) begin
      d[1:0] = {chan_b_link.error_flag, chan_a_link.error_flag};
    end else if (hit(addr, sertx_pkg::OFS_CHAR_A)) begin
      d[9:0] = chan_a_link.char_q;
    end else if (hit(addr, sertx_pkg::OFS_CHAR_B)) begin
      d[9:0] = chan_b_link.char_q;
    end else if (hit(addr, sertx_pkg::OFS_IRQ_STATUS)) begin
      d[3:0] = irq_status;
    end else if (hit(addr, sertx_pkg::OFS_IRQ_ENABLE)) begin
      d[3:0] = irq_enable;
    end
    read_word = d;
  endfunction

  // Write side: address and data are taken independently, ready drops until the response is taken
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awready <= 1'b1;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wready <= 1'b1;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // Both halves held and no response pending: commit the write
  assign do_write = ~awready & ~wready & ~bvalid;
  assign wr_hit = do_write & w_strb_q[0];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bvalid <= 1'b0;
      bresp <= sertx_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= mapped(aw_addr_q) ? sertx_pkg::RESP_OKAY : sertx_pkg::RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Configuration latches, byte 0 for channel A and byte 1 for channel B
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_a <= sertx_pkg::CFG_RESET;
      cfg_b <= sertx_pkg::CFG_RESET;
    end else if (do_write && hit(aw_addr_q, sertx_pkg::OFS_CONFIG)) begin
      if (w_strb_q[0]) begin
        cfg_a <= w_data_q[CW-1:0];
      end
      if (w_strb_q[1]) begin
        cfg_b <= w_data_q[CB+CW-1:CB];
      end
    end
  end

  // Interrupt enable
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_enable <= sertx_pkg::EVT_RESET;
    end else if (wr_hit && hit(aw_addr_q, sertx_pkg::OFS_IRQ_ENABLE)) begin
      irq_enable <= w_data_q[3:0];
    end
  end

  // Sticky events; a new event wins over a clear of the same bit
  always_comb begin
    events = sertx_pkg::EVT_RESET;
    events[sertx_pkg::EVT_BUF_A] = chan_a_link.buf_evt;
    events[sertx_pkg::EVT_BUF_B] = chan_b_link.buf_evt;
    events[sertx_pkg::EVT_BIST_A] = chan_a_link.bist_evt;
    events[sertx_pkg::EVT_BIST_B] = chan_b_link.bist_evt;
  end
  assign clr_mask = (wr_hit && hit(aw_addr_q, sertx_pkg::OFS_IRQ_CLEAR)) ? w_data_q[3:0] : 4'h0;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= sertx_pkg::EVT_RESET;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~clr_mask) | events;
      irq <= |(irq_status & irq_enable);
    end
  end

  // Read side: one read at a time, answered one edge after the address is taken
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= sertx_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= read_word(araddr);
      rresp <= mapped(araddr) ? sertx_pkg::RESP_OKAY : sertx_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // Latches steer each channel on its own
  assign chan_a_link.clk_sel = cfg_a[sertx_pkg::CFG_CLK_SEL];
  assign chan_a_link.recentre = cfg_a[sertx_pkg::CFG_RECENTRE];
  assign chan_a_link.self_test = cfg_a[sertx_pkg::CFG_SELF_TEST];
  assign chan_a_link.out1_en = cfg_a[sertx_pkg::CFG_OUT1_EN];
  assign chan_a_link.out2_en = cfg_a[sertx_pkg::CFG_OUT2_EN];
  assign chan_a_link.half_rate = cfg_a[sertx_pkg::CFG_HALF_RATE];
  assign chan_b_link.clk_sel = cfg_b[sertx_pkg::CFG_CLK_SEL];
  assign chan_b_link.recentre = cfg_b[sertx_pkg::CFG_RECENTRE];
  assign chan_b_link.self_test = cfg_b[sertx_pkg::CFG_SELF_TEST];
  assign chan_b_link.out1_en = cfg_b[sertx_pkg::CFG_OUT1_EN];
  assign chan_b_link.out2_en = cfg_b[sertx_pkg::CFG_OUT2_EN];
  assign chan_b_link.half_rate = cfg_b[sertx_pkg::CFG_HALF_RATE];

  // Two independent channels, no shared state between them
  sertx_channel #(
    .LOSS_CYCLES(LOSS_CYCLES)
  ) u_chan_a (
    .clock(clock),
    .rst_b(rst_b),
    .char_in(chan_a_char_in),
    .input_clock(chan_a_input_clock),
    .reference_clock(chan_a_reference_clock),
    .link(chan_a_link)
  );

  sertx_channel #(
    .LOSS_CYCLES(LOSS_CYCLES)
  ) u_chan_b (
    .clock(clock),
    .rst_b(rst_b),
    .char_in(chan_b_char_in),
    .input_clock(chan_b_input_clock),
    .reference_clock(chan_b_reference_clock),
    .link(chan_b_link)
  );

  // Outputs come straight from the channel flops
  assign chan_a_char_out = chan_a_link.char_q;
  assign chan_b_char_out = chan_b_link.char_q;
  assign chan_a_error_flag = chan_a_link.error_flag;
  assign chan_b_error_flag = chan_b_link.error_flag;

  // Bus, interrupt and latch checks
  sequence s_write_done;
    do_write ##1 bvalid;
  endsequence

  a_write_response: assert property (@(posedge clock) disable iff (!rst_b)
    (!awready && !wready && !bvalid) |-> s_write_done)
    else $error("write response not issued");

  a_read_answer: assert property (@(posedge clock) disable iff (!rst_b)
    (arvalid && arready) |=> rvalid && !arready)
    else $error("read not answered next cycle");

  a_read_release: assert property (@(posedge clock) disable iff (!rst_b)
    (rvalid && rready) |=> !rvalid && arready)
    else $error("read not released after handshake");

  a_event_beats_clear: assert property (@(posedge clock) disable iff (!rst_b)
    (chan_a_link.buf_evt) |=> irq_status[sertx_pkg::EVT_BUF_A])
    else $error("event lost against clear");

  a_event_b_sets: assert property (@(posedge clock) disable iff (!rst_b)
    chan_b_link.buf_evt |=> irq_status[sertx_pkg::EVT_BUF_B])
    else $error("channel B event lost");

  a_clear_drops_bit: assert property (@(posedge clock) disable iff (!rst_b)
    (clr_mask[0] && !events[0]) |=> !irq_status[0])
    else $error("status bit survived clear");

  a_irq_level: assert property (@(posedge clock) disable iff (!rst_b)
    |(irq_status & irq_enable) |=> irq)
    else $error("interrupt not raised for enabled status");

  a_config_steers: assert property (@(posedge clock) disable iff (!rst_b)
    (do_write && hit(aw_addr_q, sertx_pkg::OFS_CONFIG) && w_strb_q[0])
      |=> (chan_a_link.clk_sel == $past(w_data_q[sertx_pkg::CFG_CLK_SEL])))
    else $error("clock select latch not written");
endmodule
`default_nettype wire

/* pkg/sertx_pkg.sv */
// Shared constants for the serializer transmit front end
`default_nettype none
package sertx_pkg;
  // System clock and derived timing
  localparam int unsigned CLOCK_HZ = 40_000_000;
  localparam int unsigned REF_LOSS_NS = 2000;
  localparam int unsigned REF_LOSS_CYCLES = (REF_LOSS_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  // Character path sizes
  localparam int unsigned CHAR_W = 10;
  localparam int unsigned BIST_PERIOD = 511;
  localparam int unsigned ALIGN_DEPTH = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CHAR_A = 8'h08;
  localparam logic [7:0] OFS_CHAR_B = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  // Per-channel configuration field positions, channel B sits at CFG_B_BASE
  localparam int unsigned CFG_CLK_SEL = 0;
  localparam int unsigned CFG_RECENTRE = 1;
  localparam int unsigned CFG_SELF_TEST = 2;
  localparam int unsigned CFG_OUT1_EN = 3;
  localparam int unsigned CFG_OUT2_EN = 4;
  localparam int unsigned CFG_HALF_RATE = 5;
  localparam int unsigned CFG_W = 6;
  localparam int unsigned CFG_B_BASE = 8;
  localparam logic [5:0] CFG_RESET = 6'h1F;
  // Event bits of the interrupt registers
  localparam int unsigned EVT_BUF_A = 0;
  localparam int unsigned EVT_BUF_B = 1;
  localparam int unsigned EVT_BIST_A = 2;
  localparam int unsigned EVT_BIST_B = 3;
  localparam int unsigned EVT_W = 4;
  localparam logic [3:0] EVT_RESET = 4'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* pkg/sertx_chan_if.sv */
// Bundle between the register front end and one transmit channel
`default_nettype none
interface sertx_chan_if;
  logic clk_sel;
  logic recentre;
  logic self_test;
  logic out1_en;
  logic out2_en;
  logic half_rate;
  logic [9:0] char_q;
  logic error_flag;
  logic buf_evt;
  logic bist_evt;
  modport ctrl(output clk_sel, recentre, self_test, out1_en, out2_en, half_rate,
               input char_q, error_flag, buf_evt, bist_evt);
  modport chan(input clk_sel, recentre, self_test, out1_en, out2_en, half_rate,
               output char_q, error_flag, buf_evt, bist_evt);
endinterface
`default_nettype wire

/* hdl/sertx_channel.sv */
// One transmit channel: capture, align buffer watch, self-test and error flag
`default_nettype none
module sertx_channel #(
  parameter int unsigned DEPTH = sertx_pkg::ALIGN_DEPTH,
  parameter int unsigned BIST_LEN = sertx_pkg::BIST_PERIOD,
  parameter int unsigned LOSS_CYCLES = sertx_pkg::REF_LOSS_CYCLES
) (
  input wire logic clock, // System clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic [9:0] char_in, // Parallel character from host
  input wire logic input_clock, // Channel input clock, sampled
  input wire logic reference_clock, // Channel reference clock, sampled
  sertx_chan_if.chan link // Configuration in, status out
);
  localparam int OCC_W = $clog2(DEPTH + 1);
  localparam int BIST_W = $clog2(BIST_LEN);
  localparam int LOSS_W = $clog2(LOSS_CYCLES + 1);
  localparam logic [OCC_W-1:0] OCC_CENTRE = OCC_W'(DEPTH / 2);
  localparam logic [OCC_W-1:0] OCC_FULL = OCC_W'(DEPTH);
  localparam logic [BIST_W-1:0] BIST_LAST = BIST_W'(BIST_LEN - 1);
  localparam logic [LOSS_W-1:0] LOSS_LIMIT = LOSS_W'(LOSS_CYCLES);

  logic in_q, ref_q, in_rise, ref_rise, ref_fall, cap_stb;
  logic [9:0] char_q;
  logic [OCC_W-1:0] occ;
  logic wr, rd, ovf, udf, buf_err;
  logic [BIST_W-1:0] bist_cnt;
  logic bist_pulse, bist_wrap, bist_on;
  logic [LOSS_W-1:0] loss_cnt;
  logic ref_absent, pll_down, error_flag, buf_evt, bist_evt;

  // Edge history of the sampled clocks
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      in_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      in_q <= input_clock;
      ref_q <= reference_clock;
    end
  end
  assign in_rise = input_clock & ~in_q;
  assign ref_rise = reference_clock & ~ref_q;
  assign ref_fall = ~reference_clock & ref_q;
  // Capture edge: input clock when select is 0, reference clock otherwise
  assign cap_stb = link.clk_sel ? (ref_rise | (link.half_rate & ref_fall)) : in_rise;

  // Character register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      char_q <= 10'h000;
    end else if (cap_stb) begin
      char_q <= char_in;
    end
  end

  // Align buffer fill tracked as writes on input clock against reads on reference clock
  assign wr = ~link.clk_sel & in_rise;
  assign rd = ~link.clk_sel & ref_rise;
  assign ovf = wr & ~rd & (occ == OCC_FULL);
  assign udf = rd & ~wr & (occ == '0);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      occ <= OCC_CENTRE;
    end else if (!link.recentre || link.clk_sel) begin
      occ <= OCC_CENTRE;
    end else if (wr && !rd && !ovf) begin
      occ <= occ + 1'b1;
    end else if (rd && !wr && !udf) begin
      occ <= occ - 1'b1;
    end
  end

  // Sticky buffer error, a new fault wins over a recentre in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      buf_err <= 1'b0;
    end else if (ovf || udf) begin
      buf_err <= 1'b1;
    end else if (!link.recentre) begin
      buf_err <= 1'b0;
    end
  end

  // Self-test sequence counter, one step per character clock
  assign bist_on = ~link.self_test;
  assign bist_wrap = bist_on & ref_rise & (bist_cnt == BIST_LAST);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bist_cnt <= '0;
      bist_pulse <= 1'b0;
    end else if (!bist_on) begin
      bist_cnt <= '0;
      bist_pulse <= 1'b0;
    end else if (ref_rise) begin
      bist_cnt <= bist_wrap ? '0 : bist_cnt + 1'b1;
      bist_pulse <= bist_wrap;
    end
  end

  // Reference clock watchdog; limited to one counter, so a very slow clock reads as absent
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loss_cnt <= '0;
    end else if (ref_rise || ref_fall) begin
      loss_cnt <= '0;
    end else if (loss_cnt != LOSS_LIMIT) begin
      loss_cnt <= loss_cnt + 1'b1;
    end
  end
  assign ref_absent = (loss_cnt == LOSS_LIMIT);
  assign pll_down = ~link.out1_en & ~link.out2_en;

  // Error flag and event pulses
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      error_flag <= 1'b0;
      buf_evt <= 1'b0;
      bist_evt <= 1'b0;
    end else begin
      error_flag <= pll_down | ref_absent | (bist_on ? bist_pulse : buf_err);
      buf_evt <= ovf | udf;
      bist_evt <= bist_wrap;
    end
  end
  assign link.char_q = char_q;
  assign link.error_flag = error_flag;
  assign link.buf_evt = buf_evt;
  assign link.bist_evt = bist_evt;

  sequence s_capture;
    cap_stb ##1 1'b1;
  endsequence
  a_capture_takes_char: assert property (@(posedge clock) disable iff (!rst_b)
    cap_stb |-> s_capture ##0 (char_q == $past(char_in)))
    else $error("character not captured on selected edge");
  a_select_input_clock: assert property (@(posedge clock) disable iff (!rst_b)
    (!link.clk_sel && in_rise) |-> cap_stb)
    else $error("input clock edge not used for capture");
  a_buffer_fault_sets: assert property (@(posedge clock) disable iff (!rst_b)
    (ovf || udf) |=> buf_err ##1 (error_flag || bist_on))
    else $error("buffer fault did not raise error");
  a_buffer_err_holds: assert property (@(posedge clock) disable iff (!rst_b)
    (buf_err && link.recentre) |=> buf_err)
    else $error("buffer error dropped without recentre");
  a_recentre_clears: assert property (@(posedge clock) disable iff (!rst_b)
    (!link.recentre && !ovf && !udf) |=> !buf_err)
    else $error("recentre did not clear buffer error");
  a_bist_one_char: assert property (@(posedge clock) disable iff (!rst_b)
    (bist_pulse && ref_rise) |=> !bist_pulse)
    else $error("self-test pulse longer than one character");
  a_bist_period: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(bist_pulse) |-> ($past(bist_cnt) == BIST_LAST))
    else $error("self-test pulse at wrong count");
  a_pll_down_flag: assert property (@(posedge clock) disable iff (!rst_b)
    pll_down |=> error_flag)
    else $error("powered-down loop not flagged");
  a_ref_loss_flag: assert property (@(posedge clock) disable iff (!rst_b)
    ref_absent |=> error_flag)
    else $error("missing reference clock not flagged");
endmodule
`default_nettype wire

/* test/sertx_host_model.sv */
// Host-side model: paces characters, channel input clock and reference clock
`default_nettype none
module sertx_host_model (
  input wire logic clock, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic [2:0] in_half, // Input clock half period, 0 stops
  input wire logic [2:0] ref_half, // Reference half period, 0 stops
  input wire logic [9:0] rnd, // Next character value
  output logic [9:0] char_q, // Character to the device
  output logic input_clock, // Channel input clock
  output logic reference_clock // Channel reference clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] in_cnt;
  logic [2:0] ref_cnt;
  // Character changes only on system edges, so every sampled edge sees it settled
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) char_q <= 10'h000;
    else char_q <= rnd;
  end
  // Input clock has a pull-down, so a stopped clock reads low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      in_cnt <= 3'h0;
      input_clock <= 1'b0;
    end else if (in_half == 3'h0) begin
      in_cnt <= 3'h0;
      input_clock <= 1'b0;
    end else if (in_cnt + 3'h1 >= in_half) begin
      in_cnt <= 3'h0;
      input_clock <= ~input_clock;
    end else in_cnt <= in_cnt + 3'h1;
  end
  // Absent reference stands at its last level
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt <= 3'h0;
      reference_clock <= 1'b0;
    end else if (ref_half != 3'h0 && ref_cnt + 3'h1 >= ref_half) begin
      ref_cnt <= 3'h0;
      reference_clock <= ~reference_clock;
    end else if (ref_half != 3'h0) ref_cnt <= ref_cnt + 3'h1;
  end
endmodule
`default_nettype wire

/* test/serializer_tx_input_and_error_status_tb.sv */
// Self-checking bench for the dual-channel transmit front end
`default_nettype none
module serializer_tx_input_and_error_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_b, awvalid, wvalid, bready, arvalid, rready, chk_on, pf;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, mcfg;
  logic [1:0] bresp, rresp, pic, prc;
  logic [2:0] in_half [2];
  logic [2:0] ref_half [2];
  logic [9:0] rnd [2];
  logic [9:0] ch [2];
  logic [9:0] cho [2];
  logic [9:0] exp_c [2];
  logic ic [2];
  logic rc [2];
  logic ef [2];
  int err_total, check_count, hw;
  int q[$];
  sertx_host_model host_a (.clock(clock), .rst_b(rst_b), .in_half(in_half[0]), .ref_half(ref_half[0]),
    .rnd(rnd[0]), .char_q(ch[0]), .input_clock(ic[0]), .reference_clock(rc[0]));
  sertx_host_model host_b (.clock(clock), .rst_b(rst_b), .in_half(in_half[1]), .ref_half(ref_half[1]),
    .rnd(rnd[1]), .char_q(ch[1]), .input_clock(ic[1]), .reference_clock(rc[1]));
  sertx_top #(.LOSS_CYCLES(8)) dut_u (.clock(clock), .rst_b(rst_b), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .chan_a_char_in(ch[0]), .chan_b_char_in(ch[1]), .chan_a_input_clock(ic[0]), .chan_b_input_clock(ic[1]),
    .chan_a_reference_clock(rc[0]), .chan_b_reference_clock(rc[1]), .chan_a_char_out(cho[0]),
    .chan_b_char_out(cho[1]), .chan_a_error_flag(ef[0]), .chan_b_error_flag(ef[1]), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic fail(input string m);
    err_total++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) fail($sformatf("got %h expected %h", g, e));
  endtask
  task automatic cmp_int(input int g, input int e);
    check_count++;
    if (g != e) fail($sformatf("count %0d expected %0d", g, e));
  endtask
  // Bus write; the character check pauses while the latches move
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    chk_on <= 1'b0;
    @(posedge clock);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    for (int i = 0; i < 50; i++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        cmp_word({30'h0, bresp}, {30'h0, er});
        if (a == 8'h00) mcfg = d;
        break;
      end
      if (i == 49) fail("write hang");
    end
    repeat (8) @(posedge clock);
    chk_on <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clock);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (int i = 0; i < 50; i++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        cmp_word(rdata, e);
        cmp_word({30'h0, rresp}, {30'h0, er});
        break;
      end
      if (i == 49) fail("read hang");
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Reference model of the capture edge, from values seen before the edge
  always @(posedge clock) begin
    for (int c = 0; c < 2; c++) begin
      if (!rst_b) exp_c[c] = 10'h000;
      else if (mcfg[8*c] ? (rc[c] && !prc[c]) || (mcfg[8*c+5] && !rc[c] && prc[c]) : ic[c] && !pic[c])
        exp_c[c] = ch[c];
      pic[c] = ic[c];
      prc[c] = rc[c];
    end
    rnd[0] <= 10'($urandom);
    rnd[1] <= 10'($urandom);
  end
  always @(negedge clock) begin
    if (chk_on && rst_b) begin
      cmp_word({22'h0, cho[0]}, {22'h0, exp_c[0]});
      cmp_word({22'h0, cho[1]}, {22'h0, exp_c[1]});
    end
  end
  initial begin
    repeat (40000) @(posedge clock);
    fail("timeout");
    results();
  end
  initial begin
    void'($urandom(32'h03F0));
    {rst_b, chk_on, awvalid, wvalid, bready, arvalid, rready, pf} = 8'h00;
    {awaddr, araddr, wdata, mcfg} = {16'h0000, 32'h0, 32'h1F1F};
    in_half = '{3'h3, 3'h3};
    ref_half = '{3'h3, 3'h3};
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    chk_on <= 1'b1;
    rd(8'h00, 32'h1F1F, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h1C, 32'h0, 2'h2);
    wr(8'h1C, 32'hFFFF, 2'h2);
    $display("test reset done");
    // Reference capture, then both reference edges
    repeat (200) @(posedge clock);
    wr(8'h00, 32'h3F3F, 2'h0);
    repeat (200) @(posedge clock);
    $display("test capture done");
    // Input clock capture at equal rate, after a recentre
    wr(8'h00, 32'h1C1C, 2'h0);
    wr(8'h00, 32'h1E1E, 2'h0);
    repeat (200) @(posedge clock);
    rd(8'h04, 32'h0, 2'h0);
    $display("test input clock done");
    // Channel A input runs fast and overflows; interrupt masked first
    in_half[0] <= 3'h2;
    repeat (100) @(posedge clock);
    cmp_word({31'h0, irq}, 32'h0);
    rd(8'h04, 32'h1, 2'h0);
    rd(8'h10, 32'h1, 2'h0);
    wr(8'h18, 32'hF, 2'h0);
    cmp_word({31'h0, irq}, 32'h1);
    in_half[0] <= 3'h3;
    repeat (20) @(posedge clock);
    cmp_word({31'h0, ef[0]}, 32'h1);
    wr(8'h00, 32'h1E1C, 2'h0);
    wr(8'h14, 32'hF, 2'h0);
    cmp_word({31'h0, irq}, 32'h0);
    rd(8'h10, 32'h0, 2'h0);
    wr(8'h00, 32'h1E1E, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    $display("test overflow done");
    // Self-test on A: pulse width and spacing in system cycles
    wr(8'h00, 32'h1E1B, 2'h0);
    for (int i = 0; i < 7000; i++) begin
      @(negedge clock);
      if (ef[0] && !pf) q.push_back(i);
      if (ef[0] && q.size() == 1) hw++;
      pf = ef[0];
    end
    cmp_int(q.size() >= 2 ? q[1] - q[0] : 0, 511 * 6);
    cmp_int(hw, 6);
    $display("test self-test done");
    // Both serial outputs off on A
    wr(8'h00, 32'h1E07, 2'h0);
    cmp_word({30'h0, ef[1], ef[0]}, 32'h1);
    wr(8'h00, 32'h1F1F, 2'h0);
    cmp_word({31'h0, ef[0]}, 32'h0);
    // Reference of B goes missing, then returns
    ref_half[1] <= 3'h0;
    repeat (20) @(posedge clock);
    cmp_word({30'h0, ef[1], ef[0]}, 32'h2);
    ref_half[1] <= 3'h3;
    repeat (20) @(posedge clock);
    cmp_word({31'h0, ef[1]}, 32'h0);
    $display("test flag sources done");
    // Mid-run reset restores the latches
    wr(8'h00, 32'h3F3F, 2'h0);
    chk_on <= 1'b0;
    rst_b <= 1'b0;
    mcfg = 32'h1F1F;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    chk_on <= 1'b1;
    rd(8'h00, 32'h1F1F, 2'h0);
    cmp_word({30'h0, ef[1], ef[0]}, 32'h0);
    $display("test reset again done");
    results();
  end
endmodule
`default_nettype wire
